// ===== src/dsc_bkpt_cmp.sv
// address comparator producing force and tag breakpoint pulses
`timescale 1ns/1ps
module dsc_bkpt_cmp (
	input  wire logic clk,    // mcu clock
	input  wire logic srst,   // synchronous reset
	input  wire logic ce,     // clock enable
	dsc_bkpt_if.cmp   bk      // breakpoint carrier
);
	import dsc_pkg::*;
	// ----------------------------------------------------------------
	// match decode
	// ----------------------------------------------------------------
	wire match     = bk.enable && bk.addr_valid && (bk.cpu_addr == bk.match_addr); // R6
	wire next_force = match && bk.force_sel;                    // R7
	wire next_tag   = match && !bk.force_sel && bk.opcode_fetch; // R8
	logic force_q;
	logic tag_q;
	// register the hits
	always_ff @(posedge clk) begin
		if (srst) begin
			force_q <= 1'b0;
			tag_q   <= 1'b0;
		end else if (ce) begin
			force_q <= next_force;
			tag_q   <= next_tag;
		end
	end
	assign bk.force_hit = force_q;
	assign bk.tag_hit   = tag_q;
	AST_NO_HIT_DISABLED: assert property (@(posedge clk) disable iff (srst) // R6
		ce && !bk.enable |=> !force_q && !tag_q) else $error("hit while disabled");
	AST_FORCE_MATCH: assert property (@(posedge clk) disable iff (srst) // R7
		ce && bk.enable && bk.force_sel && bk.addr_valid && bk.cpu_addr == bk.match_addr |=> force_q)
		else $error("force match lost");
endmodule

// ===== src/dsc_bkpt_if.sv
// interface carrying breakpoint setup and matches between the modules
`timescale 1ns/1ps
interface dsc_bkpt_if;
	logic        enable;     // breakpoint enabled
	logic        force_sel;  // 1 force, 0 tag
	logic [15:0] match_addr; // breakpoint address
	logic [15:0] cpu_addr;   // cpu address bus
	logic        addr_valid; // address bus cycle qualifier
	logic        opcode_fetch; // cycle is an opcode fetch
	logic        force_hit;  // force breakpoint request
	logic        tag_hit;    // tag the fetched opcode
	modport ctrl (output enable, force_sel, match_addr, cpu_addr, addr_valid, opcode_fetch,
		input force_hit, tag_hit);
	modport cmp (input enable, force_sel, match_addr, cpu_addr, addr_valid, opcode_fetch,
		output force_hit, tag_hit);
endinterface

// ===== src/dsc_pkg.sv
// package of constants and types for the debug status and control register
package dsc_pkg;
	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int BIT_PERMIT    = 7;
	localparam int BIT_HALTED    = 6;
	localparam int BIT_BKPT_EN   = 5;
	localparam int BIT_FORCE_TAG = 4;
	localparam int BIT_CLK_SEL   = 3;
	localparam int BIT_WS        = 2;
	localparam int BIT_WSF       = 1;
	localparam int BIT_SLOW      = 0;
	// ----------------------------------------------------------------
	// reset values and widths
	// ----------------------------------------------------------------
	localparam logic [7:0] RESET_CTRL  = 8'h00;
	localparam int         ADDR_W      = 16;
	localparam logic [7:0] CTRL_WMASK  = 8'hb8; // permit, bkpt en, force/tag, clock select
	// ----------------------------------------------------------------
	// cpu run states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DSC_RUN   = 2'b00,
		DSC_WAIT  = 2'b01,
		DSC_HALT  = 2'b10
	} dsc_state_e;
	typedef logic [7:0] dsc_byte_t;
endpackage

// ===== src/dsc_status_ctrl.sv
// debug status and control register with breakpoint and halt control
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Summary of operation
// R1: reachable only through serial status/control commands
// R2: bit 7 permits active halt mode
// R3: permit sticks until normal reset
// R4: host sets permit at session start
// R5: bit 6 reads one while halted
// R6: breakpoint enable gates all matching
// R7: force select halts at instruction boundary
// R8: tag select halts when tagged opcode executes
// R9: bit 3 selects communication clock
// R10: bit 2 shows wait/stop or halt from it
// R11: only halt command served during wait/stop; control and breakpoint writes and status reads still take effect there
// R12: host confirms halted flag after forcing halt
// R13: bit 1 flags access failed by wait/stop
// R14: host recovers by halt, retry, resume
// R15: bit 0 unused, reads zero
// R16: permit locked while halted; status never written
// R17: breakpoint without permit runs software interrupt
// ----------------------------------------------------------------
module dsc_status_ctrl (
	input  wire logic                  clk,            // mcu clock
	input  wire logic                  srst,           // normal reset
	input  wire logic                  ce,             // clock enable
	input  wire logic                  ctrl_wr,        // serial control-write command pulse
	input  wire logic [7:0]            ctrl_wdata,     // control-write data
	input  wire logic                  status_rd,      // serial status-read command pulse
	output logic [7:0]                 status_rdata,   // status-read data
	output logic                       status_valid,   // status data valid pulse
	input  wire logic                  bkpt_wr,        // breakpoint address write pulse
	input  wire logic [dsc_pkg::ADDR_W-1:0] bkpt_wdata, // breakpoint address data
	input  wire logic                  halt_cmd,       // serial halt command pulse
	input  wire logic                  go_cmd,         // serial resume command pulse
	input  wire logic                  mem_cmd,        // serial memory access command pulse
	output logic                       mem_cmd_ok,     // memory command accepted
	output logic                       cmd_accept,     // non-halt command serviced
	input  wire logic                  cpu_wait_stop,  // cpu executing wait or stop
	input  wire logic                  insn_boundary,  // cpu at instruction boundary
	input  wire logic                  tag_exec,       // tagged opcode reached end of queue
	input  wire logic                  bgnd_insn,      // cpu executes halt opcode
	input  wire logic [dsc_pkg::ADDR_W-1:0] cpu_addr,  // cpu address bus
	input  wire logic                  addr_valid,     // address bus valid
	input  wire logic                  opcode_fetch,   // opcode fetch cycle
	output logic                       tag_mark,       // tag the fetched opcode
	output logic                       halted,         // cpu in active halt mode
	output logic                       swi_req,        // software interrupt request
	output logic                       comm_clock_select // 1 bus clock, 0 alternate
);
	import dsc_pkg::*;
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic        background_permit;
	logic        breakpoint_enable;
	logic        force_tag_select;
	logic        comm_clk;
	logic        wait_stop_status;
	logic        wait_stop_failure;
	logic [ADDR_W-1:0] breakpoint_match_address;
	logic        force_pend;
	logic [7:0]  rdata;
	logic        rvalid;
	logic        swi_q;
	dsc_state_e  state;
	dsc_state_e  next_state;
	dsc_bkpt_if  bk ();
	// ----------------------------------------------------------------
	// breakpoint comparator
	// ----------------------------------------------------------------
	assign bk.enable       = breakpoint_enable;
	assign bk.force_sel    = force_tag_select;
	assign bk.match_addr   = breakpoint_match_address;
	assign bk.cpu_addr     = cpu_addr;
	assign bk.addr_valid   = addr_valid;
	assign bk.opcode_fetch = opcode_fetch;
	dsc_bkpt_cmp u_cmp (
		.clk  (clk),
		.srst (srst),
		.ce   (ce),
		.bk   (bk.cmp)
	);
	// ----------------------------------------------------------------
	// decode of halt requests
	// ----------------------------------------------------------------
	// every halt source is refused once already halted, so a repeated
	// request cannot disturb the pending-force or flag logic
	wire in_halt     = (state == DSC_HALT);
	wire in_wait     = (state == DSC_WAIT);
	wire force_armed = breakpoint_enable && force_tag_select; // R6
	wire force_now   = (force_pend || bk.force_hit) && force_armed && insn_boundary && !in_halt; // R7
	wire tag_now     = tag_exec && breakpoint_enable && !force_tag_select && !in_halt; // R8
	wire bkpt_event  = force_now || tag_now;
	wire bkpt_halt   = bkpt_event && background_permit;  // R2
	wire bkpt_swi    = bkpt_event && !background_permit; // R17
	wire halt_req    = halt_cmd && background_permit && !in_halt; // R2 R11
	wire bgnd_halt   = bgnd_insn && background_permit && !in_halt;
	wire enter_halt  = halt_req || bkpt_halt || bgnd_halt;
	wire mem_fail    = mem_cmd && !in_halt && (in_wait || cpu_wait_stop); // R13
	wire permit_wr   = ctrl_wr && !in_halt;  // R16
	wire next_permit = background_permit || (permit_wr && ctrl_wdata[BIT_PERMIT]); // R3
	// next cpu state
	always_comb begin
		next_state = state;
		case (state)
			DSC_RUN: begin
				if (enter_halt)
					next_state = DSC_HALT;
				else if (cpu_wait_stop)
					next_state = DSC_WAIT;
			end
			DSC_WAIT: begin
				if (halt_req)
					next_state = DSC_HALT; // R11
				else if (!cpu_wait_stop)
					next_state = DSC_RUN;
			end
			DSC_HALT: begin
				if (go_cmd)
					next_state = DSC_RUN;
			end
			default: next_state = DSC_RUN;
		endcase
	end
	// cpu state register
	always_ff @(posedge clk) begin
		if (srst)
			state <= DSC_RUN;
		else if (ce)
			state <= next_state;
	end
	// control bits; permit only ever sets, reset clears it
	always_ff @(posedge clk) begin
		if (srst) begin
			background_permit <= RESET_CTRL[BIT_PERMIT];   // R3
			breakpoint_enable <= RESET_CTRL[BIT_BKPT_EN];
			force_tag_select  <= RESET_CTRL[BIT_FORCE_TAG];
			comm_clk          <= RESET_CTRL[BIT_CLK_SEL];  // R9
		end else if (ce) begin
			background_permit <= next_permit;
			if (ctrl_wr) begin
				breakpoint_enable <= ctrl_wdata[BIT_BKPT_EN];
				force_tag_select  <= ctrl_wdata[BIT_FORCE_TAG];
				comm_clk          <= ctrl_wdata[BIT_CLK_SEL]; // R9
			end
		end
	end
	// breakpoint address and pending force request; the pending force is
	// dropped when the breakpoint is disabled or switched to tag mode, so a
	// stale match cannot fire after the host reconfigures
	always_ff @(posedge clk) begin
		if (srst) begin
			breakpoint_match_address <= '0;
			force_pend               <= 1'b0;
		end else if (ce) begin
			if (bkpt_wr)
				breakpoint_match_address <= bkpt_wdata;
			force_pend <= (force_pend || bk.force_hit) && force_armed && !force_now && !in_halt; // R6
		end
	end
	// status flags; hardware set wins over clear
	// the wait/stop bit survives a halt taken from wait so the host can
	// tell that the cpu was asleep when it stopped it
	always_ff @(posedge clk) begin
		if (srst) begin
			wait_stop_status  <= 1'b0;
			wait_stop_failure <= 1'b0;
		end else if (ce) begin
			if (next_state == DSC_WAIT)
				wait_stop_status <= 1'b1;                  // R10
			else if (next_state == DSC_RUN)
				wait_stop_status <= 1'b0;
			else if (state != DSC_WAIT && next_state == DSC_HALT && state != DSC_HALT)
				wait_stop_status <= 1'b0;
			if (mem_fail)
				wait_stop_failure <= 1'b1;                 // R13
			else if (mem_cmd && in_halt)
				wait_stop_failure <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// serial status read, the only view of the register
	// ----------------------------------------------------------------
	wire [7:0] status_word = {background_permit, in_halt, breakpoint_enable, force_tag_select,
		comm_clk, wait_stop_status, wait_stop_failure, 1'b0}; // R1 R5 R15
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata  <= 8'h00;
			rvalid <= 1'b0;
			swi_q  <= 1'b0;
		end else if (ce) begin
			rvalid <= status_rd;
			swi_q  <= bkpt_swi; // R17
			if (status_rd)
				rdata <= status_word; // R1
		end
	end
	assign status_rdata      = rdata;
	assign status_valid      = rvalid;
	assign swi_req           = swi_q;
	assign halted            = in_halt;                 // R5
	assign comm_clock_select = comm_clk;
	assign tag_mark          = bk.tag_hit;              // R8
	assign mem_cmd_ok        = mem_cmd && !mem_fail;
	assign cmd_accept        = (ctrl_wr || status_rd || bkpt_wr || mem_cmd) && !in_wait; // R11
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	AST_PERMIT_STICKY: assert property (@(posedge clk) disable iff (srst) // R3
		background_permit |=> background_permit) else $error("permit cleared without reset");
	AST_PERMIT_LOCK: assert property (@(posedge clk) disable iff (srst) // R16
		ce && in_halt && ctrl_wr && !go_cmd |=> in_halt && background_permit) else $error("write disturbed halt");
	AST_HALT_FLAG: assert property (@(posedge clk) disable iff (srst) // R5
		status_valid |-> status_rdata[BIT_HALTED] == $past(in_halt)) else $error("halted bit wrong");
	AST_NO_HALT_NO_PERMIT: assert property (@(posedge clk) disable iff (srst) // R2
		ce && !in_halt && !background_permit |=> !in_halt) else $error("halt without permit");
	AST_SWI_ON_BKPT: assert property (@(posedge clk) disable iff (srst) // R17
		ce && bkpt_event && !background_permit |=> swi_req) else $error("no software interrupt");
	AST_CLK_SEL: assert property (@(posedge clk) disable iff (srst) // R9
		ce && ctrl_wr |=> comm_clock_select == $past(ctrl_wdata[BIT_CLK_SEL])) else $error("clock select");
	AST_WSF_SET: assert property (@(posedge clk) disable iff (srst) // R13
		ce && mem_fail |=> wait_stop_failure) else $error("wait failure not flagged");
	AST_WAIT_HALT: assert property (@(posedge clk) disable iff (srst) // R11
		ce && in_wait && halt_cmd && background_permit |=> in_halt ##0 wait_stop_status)
		else $error("halt from wait lost");
	AST_DVF_ZERO: assert property (@(posedge clk) disable iff (srst) // R15
		status_valid |-> !status_rdata[BIT_SLOW]) else $error("slow failure bit set");
	// ----------------------------------------------------------------
	// breakpoint, wait/stop and clock-enable checks
	// ----------------------------------------------------------------
	// these watch the decode terms directly, so a broken gate shows up
	// in the cycle it misbehaves rather than at the next status read
	// a disabled breakpoint raises nothing, pending or not
	AST_BKPT_OFF: assert property (@(posedge clk) disable iff (srst) // R6
		ce && !breakpoint_enable |-> !bkpt_event)
		else $error("breakpoint while disabled");
	// a written match address is the one compared from the next cycle
	AST_BKPT_ADDR: assert property (@(posedge clk) disable iff (srst) // R6
		ce && bkpt_wr |=> breakpoint_match_address == $past(bkpt_wdata))
		else $error("match address not stored");
	// a force request halts at the boundary when halting is permitted
	AST_FORCE_HALT: assert property (@(posedge clk) disable iff (srst) // R7
		ce && force_now && background_permit && !in_wait |=> in_halt)
		else $error("force breakpoint did not halt");
	// away from an instruction boundary only commands, the halt opcode or a tag breakpoint can halt
	AST_FORCE_WAITS: assert property (@(posedge clk) disable iff (srst) // R7
		ce && !in_halt && !insn_boundary && !halt_req && !bgnd_halt && !tag_now |=> !in_halt)
		else $error("halt off an instruction boundary");
	// a matching opcode fetch in tag mode marks the opcode
	AST_TAG_MARK: assert property (@(posedge clk) disable iff (srst) // R8
		ce && breakpoint_enable && !force_tag_select && addr_valid && opcode_fetch
		&& cpu_addr == breakpoint_match_address |=> tag_mark)
		else $error("opcode not tagged");
	// a tagged opcode that reaches the queue end halts instead of running
	AST_TAG_HALT: assert property (@(posedge clk) disable iff (srst) // R8
		ce && tag_exec && breakpoint_enable && !force_tag_select
		&& background_permit && !in_halt && !in_wait |=> in_halt)
		else $error("tagged opcode executed");
	// a breakpoint without permit never halts
	AST_SWI_NO_HALT: assert property (@(posedge clk) disable iff (srst) // R17
		ce && bkpt_swi |=> !in_halt)
		else $error("halt without permit on breakpoint");
	// entering wait or stop from run raises the wait/stop bit
	AST_WAIT_ENTRY: assert property (@(posedge clk) disable iff (srst) // R10
		ce && state == DSC_RUN && !enter_halt && cpu_wait_stop |=> in_wait && wait_stop_status)
		else $error("wait entry not flagged");
	// the wait/stop bit is set for the whole stay in wait or stop
	AST_WS_IN_WAIT: assert property (@(posedge clk) disable iff (srst) // R10
		in_wait |-> wait_stop_status)
		else $error("wait/stop bit low in wait");
	// the wait/stop bit is clear while the user program runs
	AST_WS_RUN_CLEAR: assert property (@(posedge clk) disable iff (srst) // R10
		state == DSC_RUN |-> !wait_stop_status)
		else $error("wait/stop bit high in run");
	// halting straight from run does not raise the wait/stop bit
	AST_WS_HALT_RUN: assert property (@(posedge clk) disable iff (srst) // R10
		ce && state == DSC_RUN && enter_halt |=> !wait_stop_status)
		else $error("wait/stop bit set by plain halt");
	// memory commands are refused in wait or stop
	AST_MEM_WAIT_REFUSED: assert property (@(posedge clk) disable iff (srst) // R11
		mem_cmd && in_wait |-> !mem_cmd_ok && !cmd_accept)
		else $error("command served in wait");
	// a memory command is served in active halt mode
	AST_MEM_HALT_SERVED: assert property (@(posedge clk) disable iff (srst) // R11
		mem_cmd && in_halt |-> mem_cmd_ok && cmd_accept)
		else $error("command refused in halt");
	// register commands are served while the user program runs
	AST_CMD_SERVED_RUN: assert property (@(posedge clk) disable iff (srst) // R11
		(ctrl_wr || status_rd) && state == DSC_RUN |-> cmd_accept)
		else $error("command refused in run");
	// a memory command served in halt clears the failure flag
	AST_WSF_CLEAR: assert property (@(posedge clk) disable iff (srst) // R13
		ce && mem_cmd && in_halt |=> !wait_stop_failure)
		else $error("wait failure not cleared");
	// control writes leave the failure flag alone
	AST_WSF_NO_WRITE: assert property (@(posedge clk) disable iff (srst) // R16
		ce && ctrl_wr && !mem_cmd |=> $stable(wait_stop_failure))
		else $error("control write changed failure flag");
	// resume leaves active halt mode
	AST_HALT_RESUME: assert property (@(posedge clk) disable iff (srst) // R5
		ce && in_halt && go_cmd |=> !halted)
		else $error("resume ignored");
	// the permit bit reads back as held
	AST_PERMIT_BIT: assert property (@(posedge clk) disable iff (srst) // R2
		status_valid |-> status_rdata[BIT_PERMIT] == $past(background_permit))
		else $error("permit bit wrong");
	// read data stands until the next status read
	AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (srst) // R1
		!status_rd |=> $stable(status_rdata))
		else $error("read data moved");
	// clock enable low freezes every register
	AST_CE_FREEZE: assert property (@(posedge clk) disable iff (srst) // R3 R9
		!ce |=> $stable(status_word) && $stable(breakpoint_match_address) && $stable(state))
		else $error("state moved with clock enable low");
	COV_HALT_CMD: cover property (@(posedge clk) disable iff (srst) halt_req ##1 in_halt);
	COV_FORCE_BKPT: cover property (@(posedge clk) disable iff (srst) force_now && background_permit);
	COV_TAG_BKPT: cover property (@(posedge clk) disable iff (srst) tag_now && background_permit);
	COV_WAIT_FAIL: cover property (@(posedge clk) disable iff (srst) mem_fail);
	// halt opcode taken by the cpu
	COV_BGND_HALT: cover property (@(posedge clk) disable iff (srst) bgnd_halt ##1 in_halt);
endmodule

// ===== tb/debug_status_control_register_tb_top.sv
// self-checking testbench for the debug status and control register
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module debug_status_control_register_tb_top;
	import dsc_pkg::*;
	logic        clk = 1'b0, srst, ce, bgnd_insn;
	logic        cpu_wait_stop, insn_boundary, tag_exec;
	logic        addr_valid, opcode_fetch;
	logic [15:0] cpu_addr, bkpt_wdata;
	logic        ctrl_wr, status_rd, bkpt_wr, halt_cmd, go_cmd, mem_cmd;
	logic [7:0]  ctrl_wdata, status_rdata;
	logic        status_valid, mem_cmd_ok, cmd_accept, tag_mark, halted, swi_req, comm_clock_select;
	logic [1:0]  rsp;
	int          n_fail = 0, samples_checked = 0, n_tag = 0, n_swi = 0;
	always #50 clk = ~clk;
	dsc_status_ctrl DUT (.clk, .srst, .ce, .ctrl_wr, .ctrl_wdata, .status_rd, .status_rdata, .status_valid,
		.bkpt_wr, .bkpt_wdata, .halt_cmd, .go_cmd, .mem_cmd, .mem_cmd_ok, .cmd_accept, .cpu_wait_stop,
		.insn_boundary, .tag_exec, .bgnd_insn, .cpu_addr, .addr_valid, .opcode_fetch, .tag_mark, .halted,
		.swi_req, .comm_clock_select);
	dsc_host_model h (.clk, .status_rdata, .status_valid, .mem_cmd_ok, .cmd_accept, .ctrl_wr, .ctrl_wdata,
		.status_rd, .bkpt_wr, .bkpt_wdata, .halt_cmd, .go_cmd, .mem_cmd);
	// count one-cycle tag and software interrupt pulses
	always @(negedge clk) begin
		if (tag_mark === 1'b1) n_tag++;
		if (swi_req === 1'b1) n_swi++;
	end
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic rd(input logic [7:0] e);
		logic [7:0] d;
		logic       v;
		h.rd(d, v);
		`CHK(v, 1'b1)
		`CHK(d, e)
	endtask
	task automatic wait_halt(input logic e);
		for (int i = 0; i < 20 && halted !== e; i++) @(negedge clk);
		`CHK(halted, e)
	endtask
	task automatic match(input logic fetch);
		@(negedge clk);
		cpu_addr = 16'h1234;
		addr_valid = 1'b1;
		opcode_fetch = fetch;
		@(negedge clk);
		{addr_valid, opcode_fetch} = 2'b00;
		cpu_addr = 16'hedcb;
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// watchdog: the sequence needs about a hundred cycles
	initial begin
		#(100 * 3000);
		n_fail++;
		stop_test();
	end
	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		{bgnd_insn, cpu_wait_stop, insn_boundary, tag_exec, addr_valid, opcode_fetch} = 6'h00;
		cpu_addr = 16'h0000;
		repeat (8) @(negedge clk);
		srst = 1'b0;
		rd(8'h00);
		`CHK(comm_clock_select, 1'b0)
		h.wr(8'hff);
		rd(8'hb8);
		`CHK(comm_clock_select, 1'b1)
		h.pulse(3'b100, rsp);
		wait_halt(1'b1);
		rd(8'hf8);
		h.wr(8'h00);
		rd(8'hc0);
		h.pulse(3'b010, rsp);
		wait_halt(1'b0);
		rd(8'h80);
		// force breakpoint waits for an instruction boundary
		h.bkpt(16'h1234);
		h.wr(8'hb0);
		match(1'b0);
		repeat (3) @(negedge clk);
		`CHK(halted, 1'b0)
		insn_boundary = 1'b1;
		wait_halt(1'b1);
		insn_boundary = 1'b0;
		rd(8'hf0);
		h.pulse(3'b010, rsp);
		wait_halt(1'b0);
		// tag breakpoint halts only when the tagged opcode executes
		h.wr(8'ha0);
		match(1'b1);
		insn_boundary = 1'b1;
		repeat (3) @(negedge clk);
		`CHK(n_tag, 1)
		`CHK(halted, 1'b0)
		tag_exec = 1'b1;
		@(negedge clk);
		tag_exec = 1'b0;
		wait_halt(1'b1);
		h.pulse(3'b010, rsp);
		wait_halt(1'b0);
		// disabled breakpoint in force mode ignores a matching opcode fetch
		h.wr(8'h90);
		match(1'b1);
		repeat (4) @(negedge clk);
		`CHK(halted, 1'b0)
		`CHK(n_tag, 1)
		insn_boundary = 1'b0;
		// wait/stop: memory command fails, halt still served, then retry
		h.wr(8'h80);
		cpu_wait_stop = 1'b1;
		repeat (2) @(negedge clk);
		h.pulse(3'b001, rsp);
		`CHK(rsp, 2'b00)
		h.pulse(3'b100, rsp);
		wait_halt(1'b1);
		rd(8'hc6);
		h.pulse(3'b001, rsp);
		`CHK(rsp, 2'b11)
		cpu_wait_stop = 1'b0;
		h.pulse(3'b010, rsp);
		wait_halt(1'b0);
		rd(8'h80);
		// halt opcode halts when permitted
		bgnd_insn = 1'b1;
		@(negedge clk);
		bgnd_insn = 1'b0;
		`CHK(halted, 1'b1)
		h.pulse(3'b010, rsp);
		wait_halt(1'b0);
		// clock enable low freezes writes and halts
		ce = 1'b0;
		h.wr(8'hb8);
		h.pulse(3'b100, rsp);
		`CHK(comm_clock_select, 1'b0)
		`CHK(halted, 1'b0)
		ce = 1'b1;
		rd(8'h80);
		// normal reset clears permit; breakpoint then runs a software interrupt
		srst = 1'b1;
		repeat (2) @(negedge clk);
		srst = 1'b0;
		rd(8'h00);
		h.pulse(3'b100, rsp);
		bgnd_insn = 1'b1;
		repeat (3) @(negedge clk);
		bgnd_insn = 1'b0;
		`CHK(halted, 1'b0)
		h.bkpt(16'h1234);
		h.wr(8'h30);
		insn_boundary = 1'b1;
		match(1'b0);
		repeat (4) @(negedge clk);
		`CHK(n_swi, 1)
		`CHK(halted, 1'b0)
		stop_test();
	end
endmodule

// ===== tb/dsc_host_model.sv
// behavioural debug host issuing serial commands to the status and control register
`timescale 1ns/1ps
module dsc_host_model (
	input  wire logic        clk,          // mcu clock
	input  wire logic [7:0]  status_rdata, // status-read data
	input  wire logic        status_valid, // status data valid
	input  wire logic        mem_cmd_ok,   // memory command accepted
	input  wire logic        cmd_accept,   // command serviced
	output logic             ctrl_wr,      // control-write pulse
	output logic [7:0]       ctrl_wdata,   // control-write data
	output logic             status_rd,    // status-read pulse
	output logic             bkpt_wr,      // breakpoint write pulse
	output logic [15:0]      bkpt_wdata,   // breakpoint address
	output logic             halt_cmd,     // halt command pulse
	output logic             go_cmd,       // resume command pulse
	output logic             mem_cmd       // memory access pulse
);
	// idle levels; released data shows the inverse of the last value
	initial begin
		{ctrl_wr, status_rd, bkpt_wr, halt_cmd, go_cmd, mem_cmd} = 6'h00;
		ctrl_wdata = 8'h00;
		bkpt_wdata = 16'h0000;
	end
	// control write, used early in a session to set the permit bit
	task automatic wr(input logic [7:0] d);
		@(negedge clk);
		ctrl_wdata = d;
		ctrl_wr = 1'b1;
		@(negedge clk);
		ctrl_wr = 1'b0;
		ctrl_wdata = ~d;
	endtask
	// status read, used to confirm the halted flag after a halt
	task automatic rd(output logic [7:0] d, output logic v);
		@(negedge clk);
		status_rd = 1'b1;
		@(negedge clk);
		status_rd = 1'b0;
		d = status_rdata;
		v = status_valid;
	endtask
	// breakpoint address write
	task automatic bkpt(input logic [15:0] a);
		@(negedge clk);
		bkpt_wdata = a;
		bkpt_wr = 1'b1;
		@(negedge clk);
		bkpt_wr = 1'b0;
		bkpt_wdata = ~a;
	endtask
	// halt, resume or memory command; halt then retry is the failure recovery
	task automatic pulse(input logic [2:0] m, output logic [1:0] r);
		@(negedge clk);
		{halt_cmd, go_cmd, mem_cmd} = m;
		#1 r = {mem_cmd_ok, cmd_accept};
		@(negedge clk);
		{halt_cmd, go_cmd, mem_cmd} = 3'b000;
	endtask
endmodule
